// ===== rtl/linsc_consts.svh
`ifndef LINSC_CONSTS_SVH
`define LINSC_CONSTS_SVH
// ==========================================================================
// Register byte offsets on the APB.
`define LS_OFF_STAT 8'h00
`define LS_OFF_DATA 8'h04
`define LS_OFF_BRR 8'h08
`define LS_OFF_CR1 8'h0c
`define LS_OFF_CR2 8'h10
`define LS_OFF_CR3 8'h14
`define LS_OFF_ERPR 8'h18
`define LS_OFF_TX_PRESCALER_VALUE 8'h1c
// ==========================================================================
// Reset and fixed values.
`define LS_REG_RST 8'h00
`define LS_HLR_RST 8'h00
`define LS_BRK_DATA 8'h00
// ==========================================================================
// Field positions.
`define LS_ST_TX_EMPTY_FLAG 7
`define LS_ST_TC 6
`define LS_ST_RX_FULL_FLAG 5
`define LS_ST_FE 1
`define LS_ST_PE 0
`define LS_CR1_PCE 2
`define LS_CR2_TE 3
`define LS_CR2_RE 2
`define LS_CR2_SBK 0
`define LS_CR3_HDF 7
`define LS_CR3_HIE 6
`define LS_CR3_HDM 5
`define LS_CR3_LINE 4
`define LS_CR3_SLV 3
`define LS_CR3_ASE 2
`define LS_ID_P0 6
`define LS_ID_P1 7
// ==========================================================================
// Character timing in oversampling ticks and bits.
`define LS_OS_MID 4'h7
`define LS_OS_LAST 4'hf
`define LS_DATA_LAST 4'h7
`define LS_BRK_LIN 4'hc
`define LS_BRK_STD 4'h9
// ==========================================================================
// Baud generation.
`define LS_PR_0 16'h0001
`define LS_PR_1 16'h0003
`define LS_PR_2 16'h0004
`define LS_PR_3 16'h000d
`define LS_LIN_STEP 13'h0010
// ==========================================================================
// Header character position after a break.
`define LS_HDR_NONE 2'h0
`define LS_HDR_SYNCH 2'h1
`define LS_HDR_ID 2'h2
`endif

// ===== rtl/linsc_pkg.sv
package linsc_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_BRK} linsc_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_WAIT} linsc_rx_t;
  typedef struct packed {
    logic [7:0] brr;
    logic [7:0] erpr;
    logic [7:0] tx_prescaler_value;
    logic [7:0] lin_prescaler_mantissa;
    logic [3:0] lin_prescaler_fraction;
    logic lin_slave;
  } linsc_baud_cfg_t;
  typedef struct packed {
    logic [1:0][15:0] cnt;
    logic [11:0] acc;
    logic [1:0] tick;
  } linsc_bst_t;
  typedef struct packed {
    logic [1:0] rx_sync;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic [7:0] cr3;
    logic [7:0] brr;
    logic [7:0] erpr;
    logic [7:0] tx_prescaler_value;
    logic [7:0] lin_prescaler_mantissa;
    logic [3:0] lin_prescaler_fraction;
    logic tx_empty_flag;
    logic tc;
    logic rx_full_flag;
    logic fe;
    logic pe;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
    logic brk_pend;
    linsc_tx_t tx_st;
    logic [7:0] tx_sh;
    logic [3:0] tx_os;
    logic [3:0] tx_bit;
    logic txd;
    linsc_rx_t rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_os;
    logic [3:0] rx_bit;
    logic [1:0] hdr_idx;
  } linsc_st_t;
endpackage : linsc_pkg

// ===== rtl/linsc_baud.sv
`timescale 1ns/100ps
`include "linsc_consts.svh"
module linsc_baud
  import linsc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Configuration.
  input wire linsc_baud_cfg_t cfg,
  // Oversampling ticks, index 0 transmit and 1 receive.
  output logic [1:0] tick
);
  linsc_bst_t st_r;
  linsc_bst_t st_nxt;
  logic [1:0][15:0] per;
  logic [11:0] lin_divider;
  logic [12:0] acc_sum;

  function automatic logic [15:0] conv(input logic [1:0] scp, input logic [2:0] sh);
    logic [15:0] pr;
    unique case (scp)
      2'h0: pr = `LS_PR_0;
      2'h1: pr = `LS_PR_1;
      2'h2: pr = `LS_PR_2;
      2'h3: pr = `LS_PR_3;
    endcase
    return pr << sh;
  endfunction : conv

  // The extended divider replaces the conventional one while non-zero. [RULE1] [RULE7]
  assign per[0] = (cfg.tx_prescaler_value != `LS_REG_RST) ? {8'h00, cfg.tx_prescaler_value} : conv(cfg.brr[7:6], cfg.brr[5:3]);
  assign per[1] = (cfg.erpr != `LS_REG_RST) ? {8'h00, cfg.erpr} : conv(cfg.brr[7:6], cfg.brr[2:0]);
  assign lin_divider = {cfg.lin_prescaler_mantissa, cfg.lin_prescaler_fraction};
  assign acc_sum = {1'h0, st_r.acc} + `LS_LIN_STEP;
  assign tick = st_r.tick;

  always_comb begin
    st_nxt = st_r;
    if (cfg.lin_slave) begin
      // One fractional divider in sixteenths feeds both directions. [RULE3] [RULE22]
      st_nxt.cnt = '0;
      st_nxt.tick = {2{acc_sum >= {1'h0, lin_divider}}};
      st_nxt.acc = st_nxt.tick[0] ? 12'(acc_sum - {1'h0, lin_divider}) : acc_sum[11:0];
    end else begin
      st_nxt.acc = '0;
      for (int ch = 0; ch < 2; ch++) begin
        st_nxt.tick[ch] = (st_r.cnt[ch] + 16'h0001) >= per[ch];
        st_nxt.cnt[ch] = st_nxt.tick[ch] ? 16'h0000 : 16'(st_r.cnt[ch] + 16'h0001);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ext_div;
    (!cfg.lin_slave && cfg.tx_prescaler_value != `LS_REG_RST && $stable(cfg)
      && st_r.cnt[0] == 16'({8'h00, cfg.tx_prescaler_value} - 16'h0001)) |=> st_r.tick[0];
  endproperty
  a_ext_div: assert property (p_ext_div) else $error("extended tx divider off"); // [RULE1]
  property p_lin_shared;
    (cfg.lin_slave && $past(cfg.lin_slave)) |-> st_r.tick[0] == st_r.tick[1];
  endproperty
  a_lin_shared: assert property (p_lin_shared) else $error("lin ticks differ"); // [RULE3]
  property p_lin_rate;
    (cfg.lin_slave && $stable(cfg) && cfg.lin_prescaler_mantissa == 8'h02 && cfg.lin_prescaler_fraction == 4'h0 && !st_r.tick[0])
      |=> st_r.tick[0];
  endproperty
  a_lin_rate: assert property (p_lin_rate) else $error("lin divider rate wrong"); // [RULE22]
endmodule : linsc_baud

// ===== rtl/linsc_top.sv
// Overview of operation
// (RULE1) Extended tx divider works only when non-zero, dividing the 16x stage by 1..255.
// (RULE2) Extended tx prescaler resets to zero, so that divider starts inactive.
// (RULE3) LIN slave uses one LIN baud generator for both directions.
// (RULE4) Software clears nine-bit mode and sets LIN enable to use LIN.
// (RULE5) LIN master send-break emits 13 low bits.
// (RULE6) LIN slave send-break write makes no break and no other effect; here the SBK bit is still stored in CR2.
// (RULE7) LIN master bit rate comes from conventional or extended prescalers.
// (RULE8) Software configures LIN mode before writing the LIN divider registers.
// (RULE9) Master header: break, clear break, send 0x55, wait empty, send identifier.
// (RULE10) Header detect method picks signalling after break or after identifier.
// (RULE11) Break detection: received break sets rx full with 0x00 and header flag.
// (RULE12) Header flag raises interrupt when enabled and processor mask clear.
// (RULE13) With auto resync, synch byte is measured only, no transfer, no full flag.
// (RULE14) Without auto resync, synch byte is received as an ordinary character; here only when header detect method is break (HDM clear).
// (RULE15) Identifier detection sets header and full flags after identifier arrives.
// (RULE16) During synch measurement the receiver transfers no character.
// (RULE17) LIN slave sets framing error for frame errors other than break.
// (RULE18) LIN slave parity check treats third character after break as identifier.
// (RULE19) Identifier parity sits in the two top bits of the character.
// (RULE20) Slave software should combine header detection with mute mode.
// (RULE21) LIN mode remaps header length, LIN mantissa and fraction addresses; here only in LIN slave mode (SLV set).
// (RULE22) LIN slave rate is clock over sixteen times 8.4 fixed-point divider.
// (RULE23) Parity P0 and P1 follow the LIN formulas; mismatch sets parity error.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "linsc_consts.svh"
module linsc_top
  import linsc_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic ARST_N,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Serial line.
  input wire logic RXD,
  output logic TXD,
  // Processor interrupt mask and header interrupt.
  input wire logic CPU_IRQ_MASK,
  output logic SCI_IRQ
);
  // ==========================================================================
  // Reset release
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ==========================================================================
  // Decoded state
  linsc_st_t st_r;
  linsc_st_t st_nxt;
  linsc_baud_cfg_t bcfg;
  logic [1:0] tick;
  logic lin_on;
  logic lin_slv;
  logic lin_mst;
  logic rx_in;
  logic apb_acc;
  logic wr;
  logic rd;
  logic char_done;
  logic brk_ev;
  logic synch_ev;
  logic id_ev;
  logic p0;
  logic p1;
  logic par_bad;
  logic [7:0] stat;
  logic [7:0] rmux;
  logic mapped;

  // Nine-bit words are not supported here, so LIN mode is the enable alone. [RULE4]
  assign lin_on = st_r.cr3[`LS_CR3_LINE];
  assign lin_slv = lin_on & st_r.cr3[`LS_CR3_SLV];
  assign lin_mst = lin_on & ~st_r.cr3[`LS_CR3_SLV];
  assign rx_in = st_r.rx_sync[1];
  assign apb_acc = PSEL & PENABLE & ~st_r.pready;
  assign wr = PSEL & PENABLE & st_r.pready & PWRITE;
  assign rd = PSEL & PENABLE & st_r.pready & ~PWRITE;
  assign char_done = (st_r.rx_st == RX_STOP) & tick[1] & (st_r.rx_os == `LS_OS_MID);
  assign brk_ev = char_done & ~rx_in & (st_r.rx_sh == `LS_BRK_DATA);
  assign synch_ev = char_done & ~brk_ev & lin_slv & (st_r.hdr_idx == `LS_HDR_SYNCH);
  assign id_ev = char_done & ~brk_ev & lin_slv & (st_r.hdr_idx == `LS_HDR_ID);
  assign p0 = st_r.rx_sh[0] ^ st_r.rx_sh[1] ^ st_r.rx_sh[2] ^ st_r.rx_sh[4];
  assign p1 = ~(st_r.rx_sh[1] ^ st_r.rx_sh[3] ^ st_r.rx_sh[4] ^ st_r.rx_sh[5]);
  // The check bits sit in the two top positions of the character. [RULE19] [RULE23]
  assign par_bad = (st_r.rx_sh[`LS_ID_P0] != p0) | (st_r.rx_sh[`LS_ID_P1] != p1);

  assign bcfg.brr = st_r.brr;
  assign bcfg.erpr = st_r.erpr;
  assign bcfg.tx_prescaler_value = st_r.tx_prescaler_value;
  assign bcfg.lin_prescaler_mantissa = st_r.lin_prescaler_mantissa;
  assign bcfg.lin_prescaler_fraction = st_r.lin_prescaler_fraction;
  // Master mode keeps the standard dividers; slave mode takes the LIN one. [RULE3] [RULE7]
  assign bcfg.lin_slave = lin_slv;

  linsc_baud u_baud (
    .clk(CLK),
    .rst_n(rst_n),
    .cfg(bcfg),
    .tick(tick)
  );

  // ==========================================================================
  // Register read view
  always_comb begin
    stat = 8'h00;
    stat[`LS_ST_TX_EMPTY_FLAG] = st_r.tx_empty_flag;
    stat[`LS_ST_TC] = st_r.tc;
    stat[`LS_ST_RX_FULL_FLAG] = st_r.rx_full_flag;
    stat[`LS_ST_FE] = st_r.fe;
    stat[`LS_ST_PE] = st_r.pe;
    mapped = 1'h1;
    rmux = 8'h00;
    case (PADDR)
      `LS_OFF_STAT: rmux = stat;
      `LS_OFF_DATA: rmux = st_r.rx_data;
      `LS_OFF_BRR: rmux = lin_slv ? st_r.lin_prescaler_mantissa : st_r.brr; // [RULE21]
      `LS_OFF_CR1: rmux = st_r.cr1;
      `LS_OFF_CR2: rmux = st_r.cr2;
      `LS_OFF_CR3: rmux = st_r.cr3;
      `LS_OFF_ERPR: rmux = lin_slv ? `LS_HLR_RST : st_r.erpr; // [RULE21]
      `LS_OFF_TX_PRESCALER_VALUE: rmux = lin_slv ? {4'h0, st_r.lin_prescaler_fraction} : st_r.tx_prescaler_value; // [RULE21]
      default: mapped = 1'h0;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rx_sync = {st_r.rx_sync[0], RXD};
    // One wait state: the answer is registered in the first access cycle.
    st_nxt.pready = apb_acc;
    st_nxt.pslverr = apb_acc & ~mapped;
    st_nxt.prdata = (apb_acc & ~PWRITE) ? {24'h000000, rmux} : 32'h00000000;
    st_nxt.irq = st_r.cr3[`LS_CR3_HDF] & st_r.cr3[`LS_CR3_HIE] & ~CPU_IRQ_MASK; // [RULE12]

    // Transmitter. It runs before the bus so that a data write in the same
    // cycle as a load is kept as the next pending character.
    if (tick[0]) begin
      unique case (st_r.tx_st)
        TX_IDLE: begin
          st_nxt.tx_os = 4'h0;
          st_nxt.tx_bit = 4'h0;
          if (st_r.cr2[`LS_CR2_TE] && st_r.brk_pend) begin
            st_nxt.brk_pend = 1'h0;
            st_nxt.txd = 1'h0;
            st_nxt.tx_st = TX_BRK; // [RULE5]
          end else if (st_r.cr2[`LS_CR2_TE] && !st_r.tx_empty_flag) begin
            // The empty flag lets a master queue the identifier after 0x55. [RULE9]
            st_nxt.tx_sh = st_r.tx_data;
            st_nxt.tx_empty_flag = 1'h1;
            st_nxt.txd = 1'h0;
            st_nxt.tx_st = TX_START;
          end
        end
        TX_START: begin
          st_nxt.tx_os = st_r.tx_os + 4'h1;
          if (st_r.tx_os == `LS_OS_LAST) begin
            st_nxt.txd = st_r.tx_sh[0];
            st_nxt.tx_st = TX_DATA;
          end
        end
        TX_DATA: begin
          st_nxt.tx_os = st_r.tx_os + 4'h1;
          if (st_r.tx_os == `LS_OS_LAST) begin
            if (st_r.tx_bit == `LS_DATA_LAST) begin
              st_nxt.txd = 1'h1;
              st_nxt.tx_st = TX_STOP;
            end else begin
              st_nxt.tx_sh = {1'h0, st_r.tx_sh[7:1]};
              st_nxt.txd = st_r.tx_sh[1];
              st_nxt.tx_bit = st_r.tx_bit + 4'h1;
            end
          end
        end
        TX_STOP: begin
          st_nxt.tx_os = st_r.tx_os + 4'h1;
          if (st_r.tx_os == `LS_OS_LAST) begin
            st_nxt.tc = st_r.tx_empty_flag;
            st_nxt.tx_st = TX_IDLE;
          end
        end
        TX_BRK: begin
          st_nxt.tx_os = st_r.tx_os + 4'h1;
          if (st_r.tx_os == `LS_OS_LAST) begin
            if (st_r.tx_bit == (lin_on ? `LS_BRK_LIN : `LS_BRK_STD)) begin
              st_nxt.txd = 1'h1;
              st_nxt.tx_st = TX_STOP;
            end else begin
              st_nxt.tx_bit = st_r.tx_bit + 4'h1;
            end
          end
        end
      endcase
    end

    // Bus writes and read side effects take place at the completing edge.
    if (wr) begin
      case (PADDR)
        `LS_OFF_DATA: begin
          st_nxt.tx_data = PWDATA[7:0];
          st_nxt.tx_empty_flag = 1'h0;
          st_nxt.tc = 1'h0;
        end
        `LS_OFF_BRR: begin
          if (lin_slv) begin
            st_nxt.lin_prescaler_mantissa = PWDATA[7:0]; // [RULE21]
          end else begin
            st_nxt.brr = PWDATA[7:0];
          end
        end
        `LS_OFF_CR1: st_nxt.cr1 = PWDATA[7:0];
        `LS_OFF_CR2: begin
          st_nxt.cr2 = PWDATA[7:0];
          // A slave queues no break; the SBK bit is still stored in CR2. [RULE5] [RULE6]
          if (!st_r.cr2[`LS_CR2_SBK] && PWDATA[`LS_CR2_SBK] && !lin_slv) begin
            st_nxt.brk_pend = 1'h1;
          end
        end
        `LS_OFF_CR3: begin
          st_nxt.cr3 = PWDATA[7:0];
          st_nxt.cr3[`LS_CR3_HDF] = st_r.cr3[`LS_CR3_HDF] & PWDATA[`LS_CR3_HDF];
        end
        `LS_OFF_ERPR: begin
          if (!lin_slv) begin
            st_nxt.erpr = PWDATA[7:0];
          end
        end
        `LS_OFF_TX_PRESCALER_VALUE: begin
          if (lin_slv) begin
            st_nxt.lin_prescaler_fraction = PWDATA[3:0]; // [RULE21]
          end else begin
            st_nxt.tx_prescaler_value = PWDATA[7:0];
          end
        end
        default: ;
      endcase
    end
    if (rd && PADDR == `LS_OFF_DATA) begin
      st_nxt.rx_full_flag = 1'h0;
      st_nxt.fe = 1'h0;
      st_nxt.pe = 1'h0;
    end

    // Receiver. It runs after the bus so that a flag set by a character
    // wins over a clear in the same cycle.
    if (tick[1]) begin
      unique case (st_r.rx_st)
        RX_IDLE: begin
          st_nxt.rx_os = 4'h0;
          st_nxt.rx_bit = 4'h0;
          if (st_r.cr2[`LS_CR2_RE] && !rx_in) begin
            st_nxt.rx_st = RX_START;
          end
        end
        RX_START: begin
          st_nxt.rx_os = st_r.rx_os + 4'h1;
          if (st_r.rx_os == `LS_OS_MID && rx_in) begin
            st_nxt.rx_st = RX_IDLE;
          end else if (st_r.rx_os == `LS_OS_LAST) begin
            st_nxt.rx_st = RX_DATA;
          end
        end
        RX_DATA: begin
          st_nxt.rx_os = st_r.rx_os + 4'h1;
          if (st_r.rx_os == `LS_OS_MID) begin
            st_nxt.rx_sh = {rx_in, st_r.rx_sh[7:1]};
          end
          if (st_r.rx_os == `LS_OS_LAST) begin
            if (st_r.rx_bit == `LS_DATA_LAST) begin
              st_nxt.rx_st = RX_STOP;
            end else begin
              st_nxt.rx_bit = st_r.rx_bit + 4'h1;
            end
          end
        end
        RX_STOP: begin
          st_nxt.rx_os = st_r.rx_os + 4'h1;
          if (st_r.rx_os == `LS_OS_MID) begin
            st_nxt.rx_st = rx_in ? RX_IDLE : RX_WAIT;
          end
        end
        RX_WAIT: begin
          if (rx_in) begin
            st_nxt.rx_st = RX_IDLE;
          end
        end
      endcase
    end

    // Character evaluation and LIN header tracking.
    if (brk_ev) begin
      st_nxt.hdr_idx = `LS_HDR_SYNCH; // [RULE18]
      if (!lin_slv) begin
        st_nxt.fe = 1'h1;
        st_nxt.rx_full_flag = 1'h1;
        st_nxt.rx_data = `LS_BRK_DATA;
      end else if (!st_r.cr3[`LS_CR3_HDM]) begin
        st_nxt.rx_full_flag = 1'h1; // [RULE10] [RULE11]
        st_nxt.rx_data = `LS_BRK_DATA;
        st_nxt.cr3[`LS_CR3_HDF] = 1'h1;
      end
    end else if (char_done) begin
      if (!rx_in) begin
        st_nxt.fe = 1'h1; // [RULE17]
      end
      if (synch_ev) begin
        st_nxt.hdr_idx = `LS_HDR_ID;
        // While the synch field is measured nothing reaches the data register.
        if (!st_r.cr3[`LS_CR3_ASE] && !st_r.cr3[`LS_CR3_HDM]) begin
          st_nxt.rx_full_flag = 1'h1; // [RULE14]
          st_nxt.rx_data = st_r.rx_sh;
        end // [RULE13] [RULE16]
      end else begin
        st_nxt.hdr_idx = `LS_HDR_NONE;
        st_nxt.rx_full_flag = 1'h1;
        st_nxt.rx_data = st_r.rx_sh;
        if (id_ev && st_r.cr3[`LS_CR3_HDM]) begin
          st_nxt.cr3[`LS_CR3_HDF] = 1'h1; // [RULE10] [RULE15]
        end
        if (id_ev && st_r.cr1[`LS_CR1_PCE] && par_bad) begin
          st_nxt.pe = 1'h1; // [RULE18] [RULE23]
        end
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.rx_sync <= 2'h3;
      st_r.tx_empty_flag <= 1'h1;
      st_r.tc <= 1'h1;
      st_r.txd <= 1'h1;
      st_r.tx_prescaler_value <= `LS_REG_RST; // [RULE2]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PRDATA = st_r.prdata;
  assign PREADY = st_r.pready;
  assign PSLVERR = st_r.pslverr;
  assign TXD = st_r.txd;
  assign SCI_IRQ = st_r.irq;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  property p_tx_prescaler_value_rst;
    $rose(rst_n) |-> st_r.tx_prescaler_value == `LS_REG_RST;
  endproperty
  a_tx_prescaler_value_rst: assert property (p_tx_prescaler_value_rst) else $error("ext tx prescaler not zero"); // [RULE2]
  property p_brk_len;
    ($fell(st_r.tx_st == TX_BRK) && lin_mst) |-> $past(st_r.tx_bit) == `LS_BRK_LIN;
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("master break length wrong"); // [RULE5]
  property p_brk_low;
    (st_r.tx_st == TX_BRK) |-> !TXD;
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("break not low"); // [RULE5]
  property p_slv_nobrk;
    (lin_slv && !st_r.brk_pend) |=> !st_r.brk_pend;
  endproperty
  a_slv_nobrk: assert property (p_slv_nobrk) else $error("slave queued a break"); // [RULE6]
  property p_brk_hdf;
    (brk_ev && lin_slv && !st_r.cr3[`LS_CR3_HDM]) |=>
      (st_r.rx_full_flag && st_r.cr3[`LS_CR3_HDF] && st_r.rx_data == `LS_BRK_DATA);
  endproperty
  a_brk_hdf: assert property (p_brk_hdf) else $error("break not signalled"); // [RULE11]
  property p_hdm_brk;
    (brk_ev && lin_slv && st_r.cr3[`LS_CR3_HDM] && !st_r.cr3[`LS_CR3_HDF])
      |=> !st_r.cr3[`LS_CR3_HDF];
  endproperty
  a_hdm_brk: assert property (p_hdm_brk) else $error("header flag early"); // [RULE10]
  property p_auto_resync_enable;
    (synch_ev && st_r.cr3[`LS_CR3_ASE] && !st_r.rx_full_flag) |=> !st_r.rx_full_flag;
  endproperty
  a_auto_resync_enable: assert property (p_auto_resync_enable) else $error("measured synch transferred"); // [RULE13]
  property p_synch_xfer;
    (synch_ev && !st_r.cr3[`LS_CR3_ASE] && !st_r.cr3[`LS_CR3_HDM])
      |=> (st_r.rx_full_flag && st_r.rx_data == $past(st_r.rx_sh));
  endproperty
  a_synch_xfer: assert property (p_synch_xfer) else $error("synch not received"); // [RULE14]
  property p_id_hdm;
    (id_ev && st_r.cr3[`LS_CR3_HDM]) |=>
      (st_r.cr3[`LS_CR3_HDF] && st_r.rx_full_flag && st_r.rx_data == $past(st_r.rx_sh));
  endproperty
  a_id_hdm: assert property (p_id_hdm) else $error("identifier header missed"); // [RULE15]
  property p_fe_brk;
    (brk_ev && lin_slv && !st_r.fe) |=> !st_r.fe;
  endproperty
  a_fe_brk: assert property (p_fe_brk) else $error("break flagged as frame error"); // [RULE17]
  property p_par;
    (id_ev && st_r.cr1[`LS_CR1_PCE] && par_bad) |=> st_r.pe;
  endproperty
  a_par: assert property (p_par) else $error("identifier parity missed"); // [RULE18] [RULE23]
  property p_irq;
    (st_r.cr3[`LS_CR3_HDF] && st_r.cr3[`LS_CR3_HIE] && !CPU_IRQ_MASK) |=> SCI_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("header interrupt missing"); // [RULE12]
  property p_remap;
    (lin_slv && apb_acc && !PWRITE && PADDR == `LS_OFF_TX_PRESCALER_VALUE)
      |=> PRDATA == {28'h0000000, $past(st_r.lin_prescaler_fraction)};
  endproperty
  a_remap: assert property (p_remap) else $error("fraction not remapped"); // [RULE21]

  c_brk_tx: cover property ($rose(st_r.tx_st == TX_BRK));
  c_hdr_id: cover property (id_ev && st_r.cr3[`LS_CR3_HDM]);
  c_synch_meas: cover property (synch_ev && st_r.cr3[`LS_CR3_ASE]);
  c_par_err: cover property (id_ev && par_bad);
endmodule : linsc_top

// ===== verification/linsc_node.sv
`timescale 1ns/100ps
module linsc_node #(
  parameter int BIT = 16
) (
  // Clock.
  input wire logic clk,
  // Bus line, recessive high.
  output logic line
);
  initial line = 1'b1;
  // Frames go out LSB first, one bit per BIT clocks, and the line returns recessive.
  task automatic send(input logic [15:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line <= f[i];
      repeat (BIT) @(posedge clk);
    end
    line <= 1'b1;
  endtask : send
endmodule : linsc_node

// ===== verification/lin_mode_serial_control_test.sv
`timescale 1ns/100ps
`include "linsc_consts.svh"
module lin_mode_serial_control_test;
  logic CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RXD, TXD, CPU_IRQ_MASK, SCI_IRQ;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic serr;
  logic [7:0] id, cr;
  int err_total = 0, comparisons = 0, cyc = 0, seed = 36608, len, e;
  linsc_top uut(.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RXD(RXD), .TXD(TXD), .CPU_IRQ_MASK(CPU_IRQ_MASK), .SCI_IRQ(SCI_IRQ));
  linsc_node #(.BIT(32)) node(.clk(CLK), .line(RXD));
  // ==========================================================================
  // Bus and check tasks.
  task automatic finish_test();
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    serr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(nm, rd, {24'h0, x});
  endtask : rdc
  task automatic low_len();
    int n;
    n = 0;
    len = 0;
    while (TXD !== 1'b0 && n < 5000) begin
      @(posedge CLK);
      n++;
    end
    while (TXD === 1'b0 && len < 5000) begin
      @(posedge CLK);
      len++;
    end
  endtask : low_len
  // ==========================================================================
  // Clock, timeout and scenarios.
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    ARST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    CPU_IRQ_MASK = 1'b0;
    repeat (20) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    rdc("status", `LS_OFF_STAT, 8'hc0);
    rdc("ext_tx_prescaler", `LS_OFF_TX_PRESCALER_VALUE, 8'h00);
    apb(1'b0, 8'h40, 8'h00);
    chk("slverr", {31'h0, serr}, 32'h1);
    apb(1'b1, `LS_OFF_CR3, 8'h10);
    apb(1'b1, `LS_OFF_CR2, 8'h09);
    low_len();
    chk("break_len", len, 13 * 16);
    e = 1 + ($unsigned($random(seed)) % 4);
    apb(1'b1, `LS_OFF_TX_PRESCALER_VALUE, e[7:0]);
    apb(1'b1, `LS_OFF_CR2, 8'h08);
    apb(1'b1, `LS_OFF_DATA, 8'(($random(seed)) | 1));
    low_len();
    chk("start_len", len, 16 * e);
    repeat (160 * e) @(posedge CLK);
    apb(1'b1, `LS_OFF_CR3, 8'h58);
    apb(1'b1, `LS_OFF_BRR, 8'h02);
    apb(1'b1, `LS_OFF_TX_PRESCALER_VALUE, 8'h00);
    apb(1'b1, `LS_OFF_ERPR, 8'h5a);
    rdc("header_length", `LS_OFF_ERPR, 8'h00);
    rdc("lin_mantissa", `LS_OFF_BRR, 8'h02);
    rdc("lin_fraction", `LS_OFF_TX_PRESCALER_VALUE, 8'h00);
    apb(1'b1, `LS_OFF_CR2, 8'h0d);
    low_len();
    chk("slave_break", len, 0);
    apb(1'b1, `LS_OFF_CR1, 8'h04);
    // Pass 0 plain break detection, pass 1 auto resync with a bad parity, pass 2 identifier mode.
    for (int h = 0; h < 3; h++) begin
      cr = {2'b01, h == 2, 2'b11, h == 1, 2'b00};
      apb(1'b1, `LS_OFF_CR3, cr);
      id[5:0] = 6'($random(seed));
      id[6] = id[0] ^ id[1] ^ id[2] ^ id[4];
      id[7] = ~(id[1] ^ id[3] ^ id[4] ^ id[5]) ^ (h == 1);
      CPU_IRQ_MASK <= h[0];
      node.send(16'h2000, 14);
      rdc("status", `LS_OFF_STAT, {2'b11, h != 2, 5'h00});
      rdc("control3", `LS_OFF_CR3, {h != 2, cr[6:0]});
      chk("irq", {31'h0, SCI_IRQ}, {31'h0, h == 0});
      if (h != 2) rdc("data", `LS_OFF_DATA, 8'h00);
      apb(1'b1, `LS_OFF_CR3, cr);
      node.send({6'h3f, 8'h55, 1'b0}, 10);
      rdc("status", `LS_OFF_STAT, {2'b11, h == 0, 5'h00});
      if (h == 0) rdc("data", `LS_OFF_DATA, 8'h55);
      node.send({6'h3f, id, 1'b0}, 10);
      rdc("status", `LS_OFF_STAT, {7'h70, h == 1});
      rdc("control3", `LS_OFF_CR3, {h == 2, cr[6:0]});
      chk("irq", {31'h0, SCI_IRQ}, {31'h0, h == 2});
      rdc("data", `LS_OFF_DATA, id);
    end
    finish_test();
  end
endmodule : lin_mode_serial_control_test
